//--- rtl/sap_pwm.sv
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module sap_pwm #(
  parameter int unsigned TB0_CYC = sap_pkg::TB0_CYC,
  parameter int unsigned TB1_CYC = sap_pkg::TB1_CYC,
  parameter int unsigned TB2_CYC = sap_pkg::TB2_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        en,
  input  wire logic [15:0] analog_in,
  input  wire logic [15:0] ext_period,
  output logic             pwm_out
);
  typedef struct packed {
    logic                en_m;
    logic                en_s;
    logic                en_d;
    logic [15:0]         ain_m;
    logic [15:0]         ain_s;
    logic                src_ext;
    logic [1:0]          tbase;
    logic signed [15:0]  gain;
    logic signed [15:0]  zero;
    logic signed [15:0]  low;
    logic signed [15:0]  high;
    logic [15:0]         period;
    logic [1:0]          dec;
    sap_pkg::sap_fsm_t   fsm;
    logic [31:0]         tick_cnt;
    logic [15:0]         per_cnt;
    logic [15:0]         per_cur;
    logic [15:0]         per_nxt;
    logic [15:0]         hi_ticks;
    logic                div_go;
    logic                pwm;
    logic                rdy;
    logic                err;
    logic [31:0]         rdata;
  } sap_state_t;
  sap_state_t s_r;
  sap_state_t s_nxt;
  // Saturate a written word into a symmetric signed range
  function automatic logic signed [15:0] sap_clamp(
    input logic [31:0]        wd,
    input logic signed [15:0] lim
  );
    logic signed [31:0] v;
    v = $signed(wd);
    v = (v > 32'(lim)) ? 32'(lim) : (v < -32'(lim)) ? -32'(lim) : v;
    return v[15:0];
  endfunction
  // Address decode shared by error answer and write steering
  function automatic logic sap_mapped(input logic [7:0] a);
    case (a)
      sap_pkg::OFS_CTRL, sap_pkg::OFS_GAIN, sap_pkg::OFS_ZERO,
      sap_pkg::OFS_LOW, sap_pkg::OFS_HIGH, sap_pkg::OFS_PERIOD,
      sap_pkg::OFS_DEC, sap_pkg::OFS_STATUS, sap_pkg::OFS_HTICKS: return 1'b1;
      default:              return 1'b0;
    endcase
  endfunction
  // Cycles in one timebase tick
  function automatic logic [31:0] sap_tb(input logic [1:0] sel);
    case (sel)
      sap_pkg::TB_1S:   return 32'(TB1_CYC);
      sap_pkg::TB_1MIN: return 32'(TB2_CYC);
      default:          return 32'(TB0_CYC);
    endcase
  endfunction
  logic signed [31:0]         prod;
  logic signed [31:0]         zero100;
  logic signed [31:0]         low100;
  logic signed [31:0]         high100;
  logic signed [33:0]         work100;
  logic signed [33:0]         dif;
  logic signed [33:0]         span;
  logic                       sat_lo;
  logic                       sat_hi;
  logic [15:0]                pnew;
  logic [sap_pkg::NUM_W-1:0]  num;
  logic [sap_pkg::DEN_W-1:0]  den;
  logic [31:0]                tb_last;
  logic                       div_done;
  logic [sap_pkg::NUM_W-1:0]  quo;
  logic [31:0]                rdv;
  // Working value kept in hundredths so the gain needs no divide
  assign prod    = $signed(s_r.ain_s) * s_r.gain;
  assign zero100 = s_r.zero * sap_pkg::SCALE;
  assign low100  = s_r.low * sap_pkg::SCALE;
  assign high100 = s_r.high * sap_pkg::SCALE;
  assign work100 = 34'(prod) + 34'(zero100);
  assign dif     = work100 - 34'(low100);
  assign span    = 34'(high100) - 34'(low100);
  // Saturation; an inverted span lands on the low side first
  assign sat_lo  = work100 <= 34'(low100);
  assign sat_hi  = work100 >= 34'(high100);
  assign pnew    = s_r.src_ext ? ((ext_period == '0) ? sap_pkg::PER_MIN
                                   : ext_period) : s_r.period;
  // In range, dif is below span, which fits the divider width
  assign num     = sat_lo ? '0 :
                   sat_hi ? 40'(pnew) :
                   40'(dif[sap_pkg::DEN_W-1:0]) * 40'(pnew);
  assign den     = (sat_lo | sat_hi) ? 24'h000001 : span[sap_pkg::DEN_W-1:0];
  assign tb_last = sap_tb(s_r.tbase) - 32'h00000001;
  sap_div u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (s_r.div_go),
    .num     (num),
    .den     (den),
    .done    (div_done),
    .quo     (quo)
  );
  // Read data; reserved bits read as zero
  always_comb begin
    case (paddr)
      sap_pkg::OFS_CTRL:   rdv = {29'h0, s_r.tbase, s_r.src_ext};
      sap_pkg::OFS_GAIN:   rdv = 32'(s_r.gain);
      sap_pkg::OFS_ZERO:   rdv = 32'(s_r.zero);
      sap_pkg::OFS_LOW:    rdv = 32'(s_r.low);
      sap_pkg::OFS_HIGH:   rdv = 32'(s_r.high);
      sap_pkg::OFS_PERIOD: rdv = {16'h0, s_r.period};
      sap_pkg::OFS_DEC:    rdv = {30'h0, s_r.dec};
      sap_pkg::OFS_STATUS: rdv = {29'h0, s_r.pwm,
                                  s_r.fsm == sap_pkg::SAP_RUN, s_r.en_s};
      sap_pkg::OFS_HTICKS: rdv = {16'h0, s_r.hi_ticks};
      default:             rdv = 32'h0;
    endcase
  end
  // Next state: synchronisers, bus slave, sequencer and output
  always_comb begin
    s_nxt        = s_r;
    s_nxt.en_m   = en;
    s_nxt.en_s   = s_r.en_m;
    s_nxt.en_d   = s_r.en_s;
    s_nxt.ain_m  = analog_in;
    s_nxt.ain_s  = s_r.ain_m;
    s_nxt.div_go = 1'b0;
    s_nxt.per_nxt = s_r.div_go ? pnew : s_r.per_nxt; // Matches divider input
    // Ready in the first access cycle, so every transfer has no wait
    s_nxt.rdy    = psel & ~penable;
    s_nxt.err    = psel & ~penable & ~sap_mapped(paddr);
    s_nxt.rdata  = (psel & ~penable) ? rdv : s_r.rdata;
    if (psel & penable & s_r.rdy & pwrite & ~s_r.err) begin
      case (paddr)
        sap_pkg::OFS_CTRL: begin
          s_nxt.src_ext = pwdata[sap_pkg::CTRL_SRC];
          s_nxt.tbase   = pwdata[sap_pkg::CTRL_TB +: 2];
        end
        sap_pkg::OFS_GAIN: s_nxt.gain = sap_clamp(pwdata,
                                          sap_pkg::GAIN_MAX);
        sap_pkg::OFS_ZERO: s_nxt.zero = sap_clamp(pwdata,
                                          sap_pkg::ZERO_MAX);
        sap_pkg::OFS_LOW:  s_nxt.low  = sap_clamp(pwdata,
                                          sap_pkg::LIM_MAX);
        sap_pkg::OFS_HIGH: s_nxt.high = sap_clamp(pwdata,
                                          sap_pkg::LIM_MAX);
        sap_pkg::OFS_PERIOD: s_nxt.period = (pwdata[15:0] == '0)
                                 ? sap_pkg::PER_MIN : pwdata[15:0];
        // Stored for software only; nothing below reads it
        sap_pkg::OFS_DEC:  s_nxt.dec = pwdata[1:0];
        default: ;
      endcase
    end
    case (s_r.fsm)
      sap_pkg::SAP_IDLE: begin
        if (s_r.en_s & ~s_r.en_d) begin
          s_nxt.fsm     = sap_pkg::SAP_CALC;
          s_nxt.div_go  = 1'b1;
        end
      end
      sap_pkg::SAP_CALC: begin
        if (div_done) begin
          s_nxt.fsm      = sap_pkg::SAP_RUN;
          s_nxt.hi_ticks = quo[15:0];
          s_nxt.per_cur  = s_r.per_nxt;
          s_nxt.div_go   = 1'b1;
        end
      end
      sap_pkg::SAP_RUN: begin
        if (s_r.tick_cnt >= tb_last) begin
          s_nxt.tick_cnt = '0;
          if (s_r.per_cnt >= s_r.per_cur - 16'h0001) begin
            // Next period's figures were worked out during this one
            s_nxt.per_cnt  = '0;
            s_nxt.hi_ticks = quo[15:0];
            s_nxt.per_cur  = s_r.per_nxt;
            s_nxt.div_go   = 1'b1;
          end else begin
            s_nxt.per_cnt = s_r.per_cnt + 16'h0001;
          end
        end else begin
          s_nxt.tick_cnt = s_r.tick_cnt + 32'h00000001;
        end
      end
      default: s_nxt.fsm = sap_pkg::SAP_IDLE;
    endcase
    if (~s_r.en_s) begin
      s_nxt.fsm      = sap_pkg::SAP_IDLE;
      s_nxt.per_cnt  = '0;
      s_nxt.tick_cnt = '0;
    end
    // High part first, low for the rest of the period
    s_nxt.pwm = (s_nxt.fsm == sap_pkg::SAP_RUN) &&
                (s_nxt.per_cnt < s_nxt.hi_ticks);
  end
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r        <= '0;
      s_r.gain   <= sap_pkg::GAIN_RST;
      s_r.zero   <= sap_pkg::ZERO_RST;
      s_r.low    <= sap_pkg::LOW_RST;
      s_r.high   <= sap_pkg::HIGH_RST;
      s_r.period <= sap_pkg::PER_RST;
      s_r.fsm    <= sap_pkg::SAP_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign prdata  = s_r.rdata;
  assign pready  = s_r.rdy;
  assign pslverr = s_r.err;
  assign pwm_out = s_r.pwm;
  // All checks run on the bus clock and pause during reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence en_rise_s;
    s_r.en_s && !s_r.en_d && s_r.fsm == sap_pkg::SAP_IDLE;
  endsequence
  sequence calc_done_s;
    s_r.fsm == sap_pkg::SAP_CALC && div_done;
  endsequence
  start_on_edge_a: assert property (
    (s_r.fsm == sap_pkg::SAP_IDLE && !(s_r.en_s && !s_r.en_d))
    |=> s_r.fsm == sap_pkg::SAP_IDLE)
    else $error("left idle without an enable edge");
  start_latency_a: assert property (
    calc_done_s ##0 s_r.en_s
    |=> s_r.fsm == sap_pkg::SAP_RUN && s_r.per_cnt == '0)
    else $error("first period did not start after calculation");
  calc_bound_a: assert property (
    en_rise_s |-> ##[1:43] (s_r.fsm != sap_pkg::SAP_CALC))
    else $error("calculation took too long");
  gain_range_a: assert property (
    s_r.gain <= sap_pkg::GAIN_MAX && s_r.gain >= -sap_pkg::GAIN_MAX &&
    s_r.zero <= sap_pkg::ZERO_MAX && s_r.zero >= -sap_pkg::ZERO_MAX)
    else $error("gain or offset outside range");
  limit_range_a: assert property (
    s_r.low <= sap_pkg::LIM_MAX && s_r.low >= -sap_pkg::LIM_MAX &&
    s_r.high <= sap_pkg::LIM_MAX && s_r.high >= -sap_pkg::LIM_MAX)
    else $error("limit outside range");
  high_first_a: assert property (
    s_r.fsm == sap_pkg::SAP_RUN && $fell(pwm_out)
    |-> s_r.tick_cnt == '0 && s_r.per_cnt == s_r.hi_ticks)
    else $error("output fell inside a tick");
  duty_cap_a: assert property (
    s_r.fsm == sap_pkg::SAP_RUN |-> s_r.hi_ticks <= s_r.per_cur)
    else $error("high time longer than period");
  period_wrap_a: assert property (
    (s_r.fsm == sap_pkg::SAP_RUN && s_r.en_s && s_r.tick_cnt >= tb_last
     && s_r.per_cnt >= s_r.per_cur - 16'h0001)
    |=> s_r.per_cnt == '0 && s_r.div_go && pwm_out == (s_r.hi_ticks != '0))
    else $error("period did not restart");
  en_low_a: assert property (
    !s_r.en_s |=> !pwm_out && s_r.per_cnt == '0 && s_r.tick_cnt == '0)
    else $error("output or timer not held while disabled");
  apb_ready_a: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("bus answer not one cycle after setup");
endmodule // sap_pwm

//--- rtl/sap_pkg.sv
package sap_pkg;

  // Clock and timebase figures
  localparam int unsigned CLK_HZ     = 25_000_000;
  localparam int unsigned TB0_MS     = 10;
  localparam int unsigned TB1_S      = 1;
  localparam int unsigned TB2_MIN    = 1;
  localparam int unsigned TB0_CYC    = CLK_HZ / 1000 * TB0_MS;
  localparam int unsigned TB1_CYC    = CLK_HZ * TB1_S;
  localparam int unsigned TB2_CYC    = CLK_HZ * 60 * TB2_MIN;

  // Timebase selector codes
  localparam logic [1:0]  TB_10MS    = 2'h0;
  localparam logic [1:0]  TB_1S      = 2'h1;
  localparam logic [1:0]  TB_1MIN    = 2'h2;

  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_GAIN   = 8'h04;
  localparam logic [7:0]  OFS_ZERO   = 8'h08;
  localparam logic [7:0]  OFS_LOW    = 8'h0C;
  localparam logic [7:0]  OFS_HIGH   = 8'h10;
  localparam logic [7:0]  OFS_PERIOD = 8'h14;
  localparam logic [7:0]  OFS_DEC    = 8'h18;
  localparam logic [7:0]  OFS_STATUS = 8'h1C;
  localparam logic [7:0]  OFS_HTICKS = 8'h20;

  // Control field positions
  localparam int          CTRL_SRC   = 0;
  localparam int          CTRL_TB    = 1;

  // Value limits: gain in hundredths, others in plain units
  localparam logic signed [15:0] GAIN_MAX = 16'sh03E8;
  localparam logic signed [15:0] ZERO_MAX = 16'sh2710;
  localparam logic signed [15:0] LIM_MAX  = 16'sh4E20;
  localparam logic signed [15:0] SCALE    = 16'sh0064;
  localparam logic [1:0]         DEC_MAX  = 2'h3;

  // Reset values
  localparam logic signed [15:0] GAIN_RST = 16'sh0064;
  localparam logic signed [15:0] ZERO_RST = 16'sh0000;
  localparam logic signed [15:0] LOW_RST  = 16'sh0000;
  localparam logic signed [15:0] HIGH_RST = 16'sh03E8;
  localparam logic [15:0]        PER_RST  = 16'h0004;
  localparam logic [15:0]        PER_MIN  = 16'h0001;

  // Divider geometry
  localparam int                 NUM_W    = 40;
  localparam int                 DEN_W    = 24;
  localparam logic [5:0]         DIV_LAST = 6'h27;

  typedef enum logic [1:0] {SAP_IDLE, SAP_CALC, SAP_RUN} sap_fsm_t;

endpackage

//--- rtl/sap_div.sv
`timescale 1ns/1ns
module sap_div (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        start,
  input  wire logic [sap_pkg::NUM_W-1:0]   num,
  input  wire logic [sap_pkg::DEN_W-1:0]   den,
  output logic                             done,
  output logic [sap_pkg::NUM_W-1:0]        quo
);

  typedef struct packed {
    logic                       busy;
    logic                       done;
    logic [5:0]                 cnt;
    logic [sap_pkg::DEN_W:0]    rem;
    logic [sap_pkg::NUM_W-1:0]  quo;
    logic [sap_pkg::DEN_W-1:0]  den;
  } sap_div_t;

  sap_div_t s_r;
  sap_div_t s_nxt;

  // One quotient bit per cycle; a new start abandons any run in flight
  always_comb begin
    logic [sap_pkg::DEN_W:0] r;
    r          = '0;
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    if (start) begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt  = '0;
      s_nxt.rem  = '0;
      s_nxt.quo  = num;
      s_nxt.den  = den;
    end else if (s_r.busy) begin
      r = {s_r.rem[sap_pkg::DEN_W-1:0], s_r.quo[sap_pkg::NUM_W-1]};
      if (r >= {1'b0, s_r.den}) begin
        r = r - {1'b0, s_r.den};
        s_nxt.quo = {s_r.quo[sap_pkg::NUM_W-2:0], 1'b1};
      end else begin
        s_nxt.quo = {s_r.quo[sap_pkg::NUM_W-2:0], 1'b0};
      end
      s_nxt.rem = r;
      s_nxt.cnt = s_r.cnt + 6'h01;
      if (s_r.cnt == sap_pkg::DIV_LAST) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign done = s_r.done;
  assign quo  = s_r.quo;

endmodule // sap_div

//--- verif/sap_far_end.sv
`timescale 1ns/1ns
// Output consumer: times the last complete high and low phases
module sap_far_end (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pwm_out,
  output logic [31:0]      hi_len,
  output logic [31:0]      lo_len
);
  logic        prev_r;
  logic [31:0] cnt_r;

  // A phase length is latched at the edge that ends it; the first phase
  // after a change is partial, so callers let a few periods pass first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= 1'b0;
      cnt_r  <= 32'h0000_0000;
      hi_len <= 32'h0000_0000;
      lo_len <= 32'h0000_0000;
    end else if (pwm_out !== prev_r) begin
      if (prev_r)
        hi_len <= cnt_r;
      else
        lo_len <= cnt_r;
      prev_r <= pwm_out;
      cnt_r  <= 32'h0000_0001;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end
endmodule // sap_far_end

//--- verif/tb_scaled_analog_pwm.sv
`timescale 1ns/1ns
module tb_scaled_analog_pwm;
  // Short ticks keep every period within a few hundred cycles
  localparam int T0 = 64;
  localparam int T1 = 128;
  localparam int T2 = 256;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        en = 1'b0;
  logic [15:0] analog_in = 16'h0000;
  logic [15:0] ext_period = 16'h0000;
  logic        pwm_out;
  logic [31:0] hi_len;
  logic [31:0] lo_len;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cyc = 0;

  sap_pwm #(.TB0_CYC(T0), .TB1_CYC(T1), .TB2_CYC(T2)) i_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .en(en),
    .analog_in(analog_in), .ext_period(ext_period), .pwm_out(pwm_out));

  sap_far_end i_far (.pclk(pclk), .presetn(presetn), .pwm_out(pwm_out),
    .hi_len(hi_len), .lo_len(lo_len));

  // 25 MHz clock
  always #20 pclk = ~pclk;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Cut a hang short well beyond the expected run length
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; answer taken at the rising edge that finds pready
  // high, and only then is the request released; the bench timeout ends
  // a wait that never sees an answer
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(a, 1'b1, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input string nm);
    logic [31:0] q;
    logic        e;
    apb(a, 1'b0, 32'h0000_0000, q, e);
    chk(nm, q, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic hold_chk(input logic exp, input int n, input string nm);
    int bad;
    bad = 0;
    repeat (n) begin
      @(posedge pclk);
      if (pwm_out !== exp)
        bad++;
    end
    chk(nm, 32'(bad), 32'h0000_0000);
  endtask

  task automatic t_regs;
    logic [31:0] q;
    logic        e;
    rd(sap_pkg::OFS_GAIN, 32'h0000_0064, "gain reset");
    rd(sap_pkg::OFS_HIGH, 32'h0000_03E8, "high reset");
    rd(sap_pkg::OFS_PERIOD, 32'h0000_0004, "period reset");
    apb(8'h40, 1'b0, 32'h0000_0000, q, e);
    chk("unmapped err", {31'h0, e}, 32'h0000_0001);
    chk("unmapped data", q, 32'h0000_0000);
    wr(sap_pkg::OFS_GAIN, 32'hFFFF_F830);
    rd(sap_pkg::OFS_GAIN, 32'hFFFF_FC18, "gain clamp");
    wr(sap_pkg::OFS_ZERO, 32'h0000_4E20);
    rd(sap_pkg::OFS_ZERO, 32'h0000_2710, "zero clamp");
    wr(sap_pkg::OFS_LOW, 32'hFFFF_8AD0);
    rd(sap_pkg::OFS_LOW, 32'hFFFF_B1E0, "low clamp");
    wr(sap_pkg::OFS_GAIN, 32'h0000_0064);
    wr(sap_pkg::OFS_ZERO, 32'h0000_0000);
    wr(sap_pkg::OFS_LOW, 32'h0000_0000);
    $display("test regs done");
  endtask

  // 500 of 0..1000 over 4 ticks: two high, two low, repeating
  task automatic t_basic;
    analog_in <= 16'h01F4;
    en        <= 1'b1;
    settle(60 + 12 * T0);
    chk("basic high", hi_len, 32'(2 * T0));
    chk("basic low", lo_len, 32'(2 * T0));
    settle(4 * T0);
    chk("repeat high", hi_len, 32'(2 * T0));
    rd(sap_pkg::OFS_HTICKS, 32'h0000_0002, "hticks");
    $display("test basic done");
  endtask

  // 100 * -2.00 + 800 = 600 over 10 ticks: six high, four low
  task automatic t_scale;
    wr(sap_pkg::OFS_GAIN, 32'hFFFF_FF38);
    wr(sap_pkg::OFS_ZERO, 32'h0000_0320);
    wr(sap_pkg::OFS_PERIOD, 32'h0000_000A);
    analog_in <= 16'h0064;
    settle(34 * T0);
    chk("scaled high", hi_len, 32'(6 * T0));
    chk("scaled low", lo_len, 32'(4 * T0));
    wr(sap_pkg::OFS_DEC, 32'h0000_0003);
    rd(sap_pkg::OFS_DEC, 32'h0000_0003, "dec readback");
    settle(20 * T0);
    chk("dec high", hi_len, 32'(6 * T0));
    $display("test scale done");
  endtask

  // Below the span, at its low edge and at its high edge the output does not toggle
  task automatic t_ends;
    logic [31:0] zv [3];
    logic        lv [3];
    zv = '{32'hFFFF_FFFB, 32'h0000_0000, 32'h0000_03E8};
    lv = '{1'b0, 1'b0, 1'b1};
    analog_in <= 16'h0000;
    for (int k = 0; k < 3; k++) begin
      wr(sap_pkg::OFS_ZERO, zv[k]);
      settle(30 * T0);
      hold_chk(lv[k], 10 * T0, "span edge level");
    end
    $display("test ends done");
  endtask

  // External period of 3 ticks under every timebase code
  task automatic t_tbase;
    int tk [4];
    tk = '{T0, T1, T2, T0};
    wr(sap_pkg::OFS_ZERO, 32'h0000_0000);
    wr(sap_pkg::OFS_GAIN, 32'h0000_0064);
    analog_in  <= 16'h01F4;
    ext_period <= 16'h0003;
    for (int k = 0; k < 4; k++) begin
      wr(sap_pkg::OFS_CTRL, {29'h0, 2'(k), 1'b1});
      settle(9 * T2 + 9 * tk[k]);
      chk("tbase high", hi_len, 32'(tk[k]));
      chk("tbase low", lo_len, 32'(2 * tk[k]));
    end
    $display("test tbase done");
  endtask

  // Disable holds the output low; a fresh edge restarts at period start
  task automatic t_enable;
    int n;
    n = 0;
    en <= 1'b0;
    settle(5);
    hold_chk(1'b0, 12 * T0, "disabled low");
    en <= 1'b1;
    while (pwm_out !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk("restart delay", {31'h0, n >= 40 && n <= 50}, 32'h1);
    settle(8 * T0);
    chk("restart high", hi_len, 32'(T0));
    $display("test enable done");
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_basic();
    t_scale();
    t_ends();
    t_tbase();
    t_enable();
    report_and_stop();
  end
endmodule // tb_scaled_analog_pwm
